//--- pkg/gpx_regs.svh
// Purpose: Register offsets, reset values and field positions of the GPIO port.
// Assumes: Byte-wide register port with 8-bit addresses.
// Notes:   Definitions only.
`ifndef GPX_REGS_SVH
`define GPX_REGS_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define GPX_OFF_DATA_B    8'h00
`define GPX_OFF_DATA_A    8'h01
`define GPX_OFF_DIR_B     8'h02
`define GPX_OFF_DIR_A     8'h03
`define GPX_OFF_PU_B      8'h04
`define GPX_OFF_PU_A      8'h05
`define GPX_OFF_PD_B      8'h06
`define GPX_OFF_PD_A      8'h07
`define GPX_OFF_BLOCK_B   8'h08
`define GPX_OFF_BLOCK_A   8'h09
`define GPX_OFF_SEL_15_12 8'h0A
`define GPX_OFF_SEL_7_4   8'h0B
`define GPX_OFF_SEL_11_8  8'h0C
`define GPX_OFF_SEL_3_0   8'h0D
`define GPX_OFF_CAUSE_B   8'h0E
`define GPX_OFF_CAUSE_A   8'h0F
`define GPX_OFF_SEEN_B    8'h10
`define GPX_OFF_SEEN_A    8'h11

// ***************************************************************
// Reset values, per bank
// ***************************************************************
`define GPX_RST_DATA      8'hFF
`define GPX_RST_DIR       8'hFF
`define GPX_RST_PU        8'h00
`define GPX_RST_PD        8'h00
`define GPX_RST_BLOCK     8'hFF
`define GPX_RST_SEL       8'h00
`define GPX_RST_FLAG      8'h00

// ***************************************************************
// Field positions
// ***************************************************************
`define GPX_BANK_B_MSB    15
`define GPX_BANK_B_LSB    8
`define GPX_BANK_A_MSB    7
`define GPX_BANK_A_LSB    0
`define GPX_SEL_FIELD_W   2
`define GPX_SYNC_STAGES   2

`endif

//--- pkg/gpx_pkg.sv
// Purpose: Shared types of the GPIO port.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in gpx_regs.svh.
package gpx_pkg;

   typedef logic [7:0] gpx_byte_t;

   typedef enum logic [1:0] {
      GPX_EDGE_NONE = 2'b00,
      GPX_EDGE_RISE = 2'b01,
      GPX_EDGE_FALL = 2'b10,
      GPX_EDGE_BOTH = 2'b11
   } gpx_edge_e;

endpackage

//--- src/gpx_line_sync.sv
// Purpose: Synchronises the pad inputs and finds their edges.
// Assumes: Pads may change at any time relative to i_clock.
// Notes:   Edge pulses last one cycle and align with the level change.
`include "gpx_regs.svh"

module gpx_line_sync #(
   parameter int WIDTH = 16
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic [WIDTH-1:0] i_pad,
   output logic [WIDTH-1:0] o_level,
   output logic [WIDTH-1:0] o_rise,
   output logic [WIDTH-1:0] o_fall
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] level_ff;
   logic [WIDTH-1:0] prev_ff;

   // The first stage is read only by the second stage.
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         meta_ff <= '0;
         level_ff <= '0;
         prev_ff <= '0;
      end else begin
         meta_ff <= i_pad;
         level_ff <= meta_ff;
         prev_ff <= level_ff;
      end
   end

   assign o_level = level_ff;
   assign o_rise = level_ff & ~prev_ff;
   assign o_fall = ~level_ff & prev_ff;

endmodule

//--- src/gpx_port.sv
// Purpose: Sixteen-line GPIO port with edge events and an interrupt output.
// Assumes: A serial front end turns host transfers into single-cycle
//          register reads and writes on the register port.
// Notes:   The strobe port stands in for the serial front end.
// Function
// [R01] Data write sets output lines; reset all ones.
// [R02] Data read returns actual pin levels.
// [R03] Direction bit 0 output, 1 input.
// [R04] Pull-up bit enables pull-up; reset off.
// [R05] Pull-down bit enables pull-down; reset off.
// [R06] Mask 0 lets events interrupt; reset masked.
// [R07] Only input lines may raise interrupt.
// [R08] Sense code: none, rising, falling, both.
// [R09] Sense registers map lines 15-12,7-4,11-8,3-0.
// [R10] Matching edge sets sticky event flag.
// [R11] Unmasked matching edge sets sticky cause flag.
// [R12] Writing 1 to cause clears cause and event.
// [R13] Writing 1 to event clears event and cause.
// [R14] Interrupt low while any cause flag set.
// [R15] Changing sense clears that line's event flag.
// [R16] Writing 0 keeps flags; new edge beats clear.
// [R17] Inputs synchronised before edge detection.
`include "gpx_regs.svh"

module gpx_port (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   input wire logic [15:0] i_io_in,
   output logic [15:0] o_io_out,
   output logic [15:0] o_io_oe,
   output logic [15:0] o_pullup_en,
   output logic [15:0] o_pulldown_en,
   output logic o_irq_out_n,
   output logic o_irq_out_n_oe
);

   // ***************************************************************
   // Storage
   // ***************************************************************
   logic [15:0] data_ff;
   logic [15:0] dir_ff;
   logic [15:0] pu_ff;
   logic [15:0] pd_ff;
   logic [15:0] block_ff;
   logic [31:0] sel_ff;
   logic [15:0] cause_ff;
   logic [15:0] seen_ff;
   logic [7:0] rdata_ff;
   logic rvalid_ff;

   logic [15:0] pin_level;
   logic [15:0] pin_rise;
   logic [15:0] pin_fall;
   logic [15:0] hit;
   logic [15:0] sel_chg;
   logic [31:0] nxt_sel;
   logic [15:0] clr_seen;
   logic [15:0] clr_cause;
   logic [15:0] nxt_seen;
   logic [15:0] nxt_cause;
   logic [7:0] nxt_rdata;

   function automatic logic wr_at(input logic [7:0] off);
      wr_at = i_reg_wr && (i_reg_addr == off);
   endfunction

   // ***************************************************************
   // Input synchronisers
   // ***************************************************************
   gpx_line_sync #(
      .WIDTH(16)
   ) gpx_line_sync_i (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_pad(i_io_in),
      .o_level(pin_level), // see [R17]
      .o_rise(pin_rise),
      .o_fall(pin_fall)
   );

   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         data_ff <= {`GPX_RST_DATA, `GPX_RST_DATA};
      end else if (wr_at(`GPX_OFF_DATA_B)) begin
         data_ff[15:8] <= i_reg_wdata; // see [R01]
      end else if (wr_at(`GPX_OFF_DATA_A)) begin
         data_ff[7:0] <= i_reg_wdata; // see [R01]
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         dir_ff <= {`GPX_RST_DIR, `GPX_RST_DIR};
      end else if (wr_at(`GPX_OFF_DIR_B)) begin
         dir_ff[15:8] <= i_reg_wdata; // see [R03]
      end else if (wr_at(`GPX_OFF_DIR_A)) begin
         dir_ff[7:0] <= i_reg_wdata; // see [R03]
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         pu_ff <= {`GPX_RST_PU, `GPX_RST_PU};
      end else if (wr_at(`GPX_OFF_PU_B)) begin
         pu_ff[15:8] <= i_reg_wdata; // see [R04]
      end else if (wr_at(`GPX_OFF_PU_A)) begin
         pu_ff[7:0] <= i_reg_wdata; // see [R04]
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         pd_ff <= {`GPX_RST_PD, `GPX_RST_PD};
      end else if (wr_at(`GPX_OFF_PD_B)) begin
         pd_ff[15:8] <= i_reg_wdata; // see [R05]
      end else if (wr_at(`GPX_OFF_PD_A)) begin
         pd_ff[7:0] <= i_reg_wdata; // see [R05]
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         block_ff <= {`GPX_RST_BLOCK, `GPX_RST_BLOCK};
      end else if (wr_at(`GPX_OFF_BLOCK_B)) begin
         block_ff[15:8] <= i_reg_wdata; // see [R06]
      end else if (wr_at(`GPX_OFF_BLOCK_A)) begin
         block_ff[7:0] <= i_reg_wdata; // see [R06]
      end
   end

   // The sense registers are held as one vector indexed by line number.
   always_comb begin
      nxt_sel = sel_ff;
      if (wr_at(`GPX_OFF_SEL_3_0)) begin
         nxt_sel[7:0] = i_reg_wdata; // see [R09]
      end
      if (wr_at(`GPX_OFF_SEL_7_4)) begin
         nxt_sel[15:8] = i_reg_wdata; // see [R09]
      end
      if (wr_at(`GPX_OFF_SEL_11_8)) begin
         nxt_sel[23:16] = i_reg_wdata; // see [R09]
      end
      if (wr_at(`GPX_OFF_SEL_15_12)) begin
         nxt_sel[31:24] = i_reg_wdata; // see [R09]
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         sel_ff <= {4{`GPX_RST_SEL}};
      end else begin
         sel_ff <= nxt_sel;
      end
   end

   // ***************************************************************
   // Edge qualification per line
   // ***************************************************************
   for (genvar gi = 0; gi < 16; gi++) begin : g_line
      gpx_pkg::gpx_edge_e mode;
      assign mode = gpx_pkg::gpx_edge_e'(sel_ff[2*gi +: 2]);
      always_comb begin
         case (mode)
            gpx_pkg::GPX_EDGE_NONE: hit[gi] = 1'b0; // see [R08]
            gpx_pkg::GPX_EDGE_RISE: hit[gi] = pin_rise[gi];
            gpx_pkg::GPX_EDGE_FALL: hit[gi] = pin_fall[gi];
            gpx_pkg::GPX_EDGE_BOTH: hit[gi] = pin_rise[gi] | pin_fall[gi];
            default: hit[gi] = 1'b0;
         endcase
      end
      assign sel_chg[gi] = nxt_sel[2*gi +: 2] != sel_ff[2*gi +: 2]; // see [R15]
   end

   // ***************************************************************
   // Sticky flags
   // ***************************************************************
   always_comb begin
      clr_cause = 16'h0000;
      clr_seen = sel_chg; // see [R15]
      if (wr_at(`GPX_OFF_CAUSE_B)) begin
         clr_cause[15:8] = clr_cause[15:8] | i_reg_wdata; // see [R12]
      end
      if (wr_at(`GPX_OFF_CAUSE_A)) begin
         clr_cause[7:0] = clr_cause[7:0] | i_reg_wdata; // see [R12]
      end
      if (wr_at(`GPX_OFF_SEEN_B)) begin
         clr_seen[15:8] = clr_seen[15:8] | i_reg_wdata; // see [R13]
         clr_cause[15:8] = clr_cause[15:8] | i_reg_wdata;
      end
      if (wr_at(`GPX_OFF_SEEN_A)) begin
         clr_seen[7:0] = clr_seen[7:0] | i_reg_wdata; // see [R13]
         clr_cause[7:0] = clr_cause[7:0] | i_reg_wdata;
      end
      // A cause clear also drops the event flag of the same line.
      clr_seen = clr_seen | clr_cause; // see [R12]
   end

   // A new edge is ORed in after the clear so that it is never lost.
   assign nxt_seen = (seen_ff & ~clr_seen) | hit; // see [R10] see [R16]
   assign nxt_cause = (cause_ff & ~clr_cause) | (hit & ~block_ff & dir_ff); // see [R11] see [R07]

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         seen_ff <= {`GPX_RST_FLAG, `GPX_RST_FLAG};
      end else begin
         seen_ff <= nxt_seen;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         cause_ff <= {`GPX_RST_FLAG, `GPX_RST_FLAG};
      end else begin
         cause_ff <= nxt_cause;
      end
   end

   // ***************************************************************
   // Read port
   // ***************************************************************
   always_comb begin
      case (i_reg_addr)
         `GPX_OFF_DATA_B: nxt_rdata = pin_level[15:8]; // see [R02]
         `GPX_OFF_DATA_A: nxt_rdata = pin_level[7:0]; // see [R02]
         `GPX_OFF_DIR_B: nxt_rdata = dir_ff[15:8];
         `GPX_OFF_DIR_A: nxt_rdata = dir_ff[7:0];
         `GPX_OFF_PU_B: nxt_rdata = pu_ff[15:8];
         `GPX_OFF_PU_A: nxt_rdata = pu_ff[7:0];
         `GPX_OFF_PD_B: nxt_rdata = pd_ff[15:8];
         `GPX_OFF_PD_A: nxt_rdata = pd_ff[7:0];
         `GPX_OFF_BLOCK_B: nxt_rdata = block_ff[15:8];
         `GPX_OFF_BLOCK_A: nxt_rdata = block_ff[7:0];
         `GPX_OFF_SEL_15_12: nxt_rdata = sel_ff[31:24];
         `GPX_OFF_SEL_7_4: nxt_rdata = sel_ff[15:8];
         `GPX_OFF_SEL_11_8: nxt_rdata = sel_ff[23:16];
         `GPX_OFF_SEL_3_0: nxt_rdata = sel_ff[7:0];
         `GPX_OFF_CAUSE_B: nxt_rdata = cause_ff[15:8];
         `GPX_OFF_CAUSE_A: nxt_rdata = cause_ff[7:0];
         `GPX_OFF_SEEN_B: nxt_rdata = seen_ff[15:8];
         `GPX_OFF_SEEN_A: nxt_rdata = seen_ff[7:0];
         default: nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= i_reg_rd;
         if (i_reg_rd) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign o_reg_rdata = rdata_ff;
   assign o_reg_rvalid = rvalid_ff;
   assign o_io_out = data_ff; // see [R01]
   assign o_io_oe = ~dir_ff; // see [R03]
   assign o_pullup_en = pu_ff; // see [R04]
   assign o_pulldown_en = pd_ff; // see [R05]
   // Open drain: the pin is only ever pulled low, never driven high.
   assign o_irq_out_n = 1'b0;
   assign o_irq_out_n_oe = |cause_ff; // see [R14]

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);

   sequence s_write_data_b;
      i_reg_wr && i_reg_addr == `GPX_OFF_DATA_B;
   endsequence

   sequence s_rise_line0;
      sel_ff[1:0] == 2'b01 && $rose(pin_level[0]);
   endsequence

   sequence s_flags_drained;
      cause_ff != 16'h0000 ##1 cause_ff == 16'h0000;
   endsequence

   a_data_drive: assert property (s_write_data_b |=> o_io_out[15:8] == $past(i_reg_wdata)) // see [R01]
      else $error("bank b output data not taken from write");

   a_read_level: assert property (i_reg_rd && i_reg_addr == `GPX_OFF_DATA_A
      |=> o_reg_rvalid && o_reg_rdata == $past(pin_level[7:0])) // see [R02]
      else $error("data read does not show pin level");

   a_dir_enable: assert property (i_reg_wr && i_reg_addr == `GPX_OFF_DIR_A
      |=> o_io_oe[7:0] == ~$past(i_reg_wdata)) // see [R03]
      else $error("direction write not reflected on enables");

   a_pull_enable: assert property (i_reg_wr && i_reg_addr == `GPX_OFF_PU_B
      |=> o_pullup_en[15:8] == $past(i_reg_wdata) && $stable(o_pulldown_en)) // see [R04]
      else $error("pull-up write wrong");

   a_pulldn_enable: assert property (i_reg_wr && i_reg_addr == `GPX_OFF_PD_A
      |=> o_pulldown_en[7:0] == $past(i_reg_wdata)) // see [R05]
      else $error("pull-down write wrong");

   a_cause_gate: assert property ($rose(cause_ff[0])
      |-> !$past(block_ff[0]) && $past(dir_ff[0]) && $past(hit[0])) // see [R06]
      else $error("cause set on masked or output line");

   a_edge_none: assert property ($rose(seen_ff[0]) |-> $past(sel_ff[1:0]) != 2'b00) // see [R08]
      else $error("event seen with sensitivity none");

   a_sense_map: assert property (i_reg_wr && i_reg_addr == `GPX_OFF_SEL_15_12
      |=> sel_ff[31:30] == $past(i_reg_wdata[7:6])) // see [R09]
      else $error("line 15 sense field misplaced");

   a_rise_event: assert property (s_rise_line0 |=> seen_ff[0] ##1 seen_ff[0] || $past(clr_seen[0])) // see [R10]
      else $error("rising edge not recorded as sticky");

   a_cause_clear: assert property (i_reg_wr && i_reg_addr == `GPX_OFF_CAUSE_A
      && i_reg_wdata[0] && !hit[0] |=> !cause_ff[0] && !seen_ff[0]) // see [R12]
      else $error("cause clear did not drop both flags");

   a_seen_clear: assert property (i_reg_wr && i_reg_addr == `GPX_OFF_SEEN_B
      && i_reg_wdata[0] && !hit[8] |=> !seen_ff[8] && !cause_ff[8]) // see [R13]
      else $error("event clear did not drop flags");

   a_irq_release: assert property (s_flags_drained |-> !o_irq_out_n_oe && $past(o_irq_out_n_oe)) // see [R14]
      else $error("interrupt not released when flags drained");

   a_stale_event: assert property (i_reg_wr && i_reg_addr == `GPX_OFF_SEL_3_0
      && i_reg_wdata[1:0] != sel_ff[1:0] && !hit[0] |=> !seen_ff[0]) // see [R15]
      else $error("sense change left a stale event");

   a_set_wins: assert property (hit[0] && i_reg_wr && i_reg_addr == `GPX_OFF_SEEN_A
      && i_reg_wdata[0] |=> seen_ff[0]) // see [R16]
      else $error("new edge lost to clear");

   a_single_event: assert property (pin_rise[0] |=> !pin_rise[0]) // see [R17]
      else $error("one transition gave two events");

endmodule

//--- testbench/gpx_host_model.sv
// Purpose: Host stand-in that issues register reads and writes to the port.
// Assumes: One strobe per transfer, changed only on the falling edge.
// Notes:   Released address and data lines show the inverse of their last value.
module gpx_host_model (
   input wire logic i_clock,
   output logic [7:0] o_reg_addr,
   output logic o_reg_wr,
   output logic [7:0] o_reg_wdata,
   output logic o_reg_rd,
   input wire logic [7:0] i_reg_rdata,
   input wire logic i_reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_reg_addr = 8'h00;
      o_reg_wr = 1'b0;
      o_reg_wdata = 8'h00;
      o_reg_rd = 1'b0;
   end

   task automatic put(input logic [7:0] addr, input logic [7:0] data, input logic rd);
      @(negedge i_clock);
      o_reg_addr = addr;
      o_reg_wdata = data;
      o_reg_wr = ~rd;
      o_reg_rd = rd;
      @(negedge i_clock);
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
      // A stale address must never pass for a held request.
      o_reg_addr = ~addr;
      o_reg_wdata = ~data;
   endtask

   task automatic write(input logic [7:0] addr, input logic [7:0] data);
      put(addr, data, 1'b0);
   endtask

   task automatic clear(input logic [7:0] addr, input logic [7:0] bits);
      put(addr, bits, 1'b0);
   endtask

   task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      put(addr, 8'h00, 1'b1);
      ok = 1'b0;
      data = 8'h00;
      for (int n = 0; n < 4 && !ok; n++) begin
         if (i_reg_rvalid === 1'b1) begin
            data = i_reg_rdata;
            ok = 1'b1;
         end else begin
            @(negedge i_clock);
         end
      end
   endtask
endmodule

//--- testbench/gpx_port_tb.sv
// Purpose: Self-checking bench for the sixteen-line port.
// Assumes: Pads resolve from device drive, bench drive, then pulls.
// Notes:   Flag checks wait five cycles, two beyond the edge-to-flag delay.
module gpx_port_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clock;
   logic nrst;
   logic [7:0] reg_addr;
   logic reg_wr;
   logic [7:0] reg_wdata;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic [15:0] io_out;
   logic [15:0] io_oe;
   logic [15:0] pu;
   logic [15:0] pd;
   logic [15:0] pad;
   logic [15:0] ext_en;
   logic [15:0] ext_val;
   logic irq_n;
   logic irq_oe;
   logic irq_line;
   int num_errors;
   int checks_done;

   // ****************************************************************
   // Pads and the shared interrupt line
   // ****************************************************************
   for (genvar g = 0; g < 16; g++) begin : g_pad
      assign pad[g] = io_oe[g] ? io_out[g] : ext_en[g] ? ext_val[g] : pu[g] | ~pd[g];
   end
   // The interrupt line is open drain with a pull-up on the board.
   assign irq_line = irq_oe ? irq_n : 1'b1;

   gpx_port gpx_port_i (
      .i_clock(clock),
      .i_nrst(nrst),
      .i_reg_addr(reg_addr),
      .i_reg_wr(reg_wr),
      .i_reg_wdata(reg_wdata),
      .i_reg_rd(reg_rd),
      .o_reg_rdata(reg_rdata),
      .o_reg_rvalid(reg_rvalid),
      .i_io_in(pad),
      .o_io_out(io_out),
      .o_io_oe(io_oe),
      .o_pullup_en(pu),
      .o_pulldown_en(pd),
      .o_irq_out_n(irq_n),
      .o_irq_out_n_oe(irq_oe)
   );

   gpx_host_model gpx_host_model_i (
      .i_clock(clock),
      .o_reg_addr(reg_addr),
      .o_reg_wr(reg_wr),
      .o_reg_wdata(reg_wdata),
      .o_reg_rd(reg_rd),
      .i_reg_rdata(reg_rdata),
      .i_reg_rvalid(reg_rvalid)
   );

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic wrap_up();
      if (num_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic chk_reg(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] got;
      logic ok;
      gpx_host_model_i.read(addr, got, ok);
      if (ok !== 1'b1) begin
         num_errors++;
         $display("wrong value read valid of %h expected 1 seen %b", addr, ok);
         wrap_up();
      end else begin
         checks_done++;
         if (got !== exp) begin
            num_errors++;
            $display("wrong value register %h expected %h seen %h", addr, exp, got);
         end
      end
   endtask

   task automatic chk_pins(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic reset_values();
      gpx_host_model_i.write(8'h12, 8'hFF);
      for (int a = 0; a < 19; a++) begin
         chk_reg(8'(a), (a inside {2, 3, 8, 9}) ? 8'hFF : 8'h00);
      end
      chk_pins("io_out", 16'hFFFF, io_out);
      chk_pins("io_oe", 16'h0000, io_oe);
      chk_pins("pullup", 16'h0000, pu);
      chk_pins("pulldown", 16'h0000, pd);
      chk_pins("irq", 16'h0001, {15'h0000, irq_line});
   endtask

   task automatic drive_and_read();
      gpx_host_model_i.write(8'h02, 8'h0F);
      gpx_host_model_i.write(8'h00, 8'hA5);
      gpx_host_model_i.write(8'h05, 8'h3C);
      gpx_host_model_i.write(8'h07, 8'hC3);
      ext_en = 16'h0F00;
      ext_val = 16'h0600;
      idle(4);
      chk_pins("io_oe", 16'hF000, io_oe);
      chk_pins("io_out", 16'hA5FF, io_out);
      chk_pins("pullup", 16'h003C, pu);
      chk_pins("pulldown", 16'h00C3, pd);
      chk_reg(8'h00, 8'hA6);
      chk_reg(8'h01, 8'h3C);
      gpx_host_model_i.write(8'h01, 8'h00);
      idle(4);
      chk_pins("io_out", 16'hA500, io_out);
      chk_reg(8'h01, 8'h3C);
      gpx_host_model_i.write(8'h02, 8'hFF);
      gpx_host_model_i.write(8'h05, 8'h00);
      gpx_host_model_i.write(8'h07, 8'h00);
      ext_en = 16'hFFFF;
      ext_val = 16'h0000;
      idle(5);
   endtask

   task automatic edge_codes();
      for (int c = 0; c < 4; c++) begin
         gpx_host_model_i.write(8'h0D, 8'(c));
         gpx_host_model_i.clear(8'h11, 8'hFF);
         ext_val[0] = 1'b1;
         idle(5);
         chk_reg(8'h11, {7'h00, c[0]});
         gpx_host_model_i.clear(8'h11, 8'h01);
         ext_val[0] = 1'b0;
         idle(5);
         chk_reg(8'h11, {7'h00, c[1]});
         chk_reg(8'h0F, 8'h00);
      end
   endtask

   task automatic line_map();
      logic [7:0] addr;
      logic [7:0] seen;
      for (int l = 0; l < 16; l++) begin
         addr = (l < 4) ? 8'h0D : (l < 8) ? 8'h0B : (l < 12) ? 8'h0C : 8'h0A;
         seen = (l < 8) ? 8'h11 : 8'h10;
         gpx_host_model_i.write(addr, 8'h01 << (2 * (l % 4)));
         ext_val[l] = 1'b1;
         idle(5);
         chk_reg(seen, 8'h01 << (l % 8));
         gpx_host_model_i.clear(seen, 8'hFF);
         gpx_host_model_i.write(addr, 8'h00);
         ext_val[l] = 1'b0;
      end
      idle(5);
   endtask

   task automatic irq_flow();
      gpx_host_model_i.write(8'h01, 8'hFF);
      gpx_host_model_i.write(8'h03, 8'hF7);
      gpx_host_model_i.write(8'h0D, 8'hC1);
      gpx_host_model_i.write(8'h0C, 8'h14);
      gpx_host_model_i.write(8'h09, 8'hF6);
      gpx_host_model_i.write(8'h08, 8'hFD);
      idle(5);
      gpx_host_model_i.clear(8'h10, 8'hFF);
      gpx_host_model_i.clear(8'h11, 8'hFF);
      ext_val[0] = 1'b1;
      ext_val[10:9] = 2'b11;
      // Line 3 is an output, so its edge comes from the data register.
      gpx_host_model_i.write(8'h01, 8'hF7);
      idle(5);
      chk_reg(8'h11, 8'h09);
      chk_reg(8'h0F, 8'h01);
      chk_reg(8'h10, 8'h06);
      chk_reg(8'h0E, 8'h02);
      chk_pins("irq", 16'h0000, {15'h0000, irq_line});
      gpx_host_model_i.clear(8'h11, 8'h01);
      chk_reg(8'h11, 8'h08);
      chk_reg(8'h0F, 8'h00);
      chk_pins("irq", 16'h0000, {15'h0000, irq_line});
      gpx_host_model_i.write(8'h0E, 8'h00);
      chk_reg(8'h0E, 8'h02);
      gpx_host_model_i.clear(8'h0E, 8'h02);
      chk_reg(8'h0E, 8'h00);
      chk_reg(8'h10, 8'h04);
      chk_pins("irq", 16'h0001, {15'h0000, irq_line});
      gpx_host_model_i.write(8'h0C, 8'h04);
      chk_reg(8'h10, 8'h00);
   endtask

   task automatic set_wins();
      // Line 0 is an unmasked rising-edge input here; its fall gives no event.
      ext_val[0] = 1'b0;
      idle(5);
      ext_val[0] = 1'b1;
      idle(1);
      // The clear lands on the very edge at which the new rise is flagged.
      gpx_host_model_i.clear(8'h11, 8'h01);
      chk_reg(8'h11, 8'h09);
      chk_reg(8'h0F, 8'h01);
      chk_pins("irq", 16'h0000, {15'h0000, irq_line});
      gpx_host_model_i.clear(8'h0F, 8'h01);
      chk_reg(8'h11, 8'h08);
      chk_pins("irq", 16'h0001, {15'h0000, irq_line});
   endtask

   // ****************************************************************
   // Clock, reset and main sequence
   // ****************************************************************
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   initial begin
      num_errors = 0;
      checks_done = 0;
      nrst = 1'b0;
      ext_en = 16'hFFFF;
      ext_val = 16'h0000;
      repeat (12) @(negedge clock);
      nrst = 1'b1;
      reset_values();
      drive_and_read();
      edge_codes();
      line_map();
      irq_flow();
      set_wins();
      wrap_up();
   end
endmodule
